// ==== bench/bcid_core_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
module bcid_core_assertions
	import bcid_pkg::*;
(
	// Clock and reset
	input wire logic        clk_i,
	input wire logic        resetn_i,
	// Watched ports
	input wire logic [12:0] prog_addr_o,
	input wire logic [13:0] instr_i,
	input wire logic [7:0]  portb_pin_i,
	input wire logic [7:0]  portb_out_o,
	input wire logic        sleeping_o,
	input wire logic [7:0]  acc_o
);
	logic [12:0] prev_pc_reg;
	logic [12:0] prev_pc_next;
	logic        exec;
	logic [7:0]  lit;
	logic [10:0] tgt;

	// A jump in the address marks a dead cycle; interrupt entry is not modelled
	assign prev_pc_next = prog_addr_o;
	assign exec = !sleeping_o && (prog_addr_o == prev_pc_reg ||
		prog_addr_o == prev_pc_reg + 13'h0001);
	assign lit = instr_i[7:0];
	assign tgt = instr_i[10:0];

	always_ff @(posedge clk_i or negedge resetn_i)
		if (!resetn_i)
			prev_pc_reg <= 13'h0000;
		else
			prev_pc_reg <= prev_pc_next;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);

	AST_OR_LIT: assert property (exec && instr_i[13:8] == 6'h38 |=>
		acc_o == ($past(acc_o) | $past(lit)))
		else $error("literal or result wrong");
	AST_XOR_LIT: assert property (exec && instr_i[13:8] == 6'h3a |=>
		acc_o == ($past(acc_o) ^ $past(lit)))
		else $error("literal xor result wrong");
	AST_SUB_LIT: assert property (exec && instr_i[13:9] == 5'h1e |=>
		acc_o == $past(lit) - $past(acc_o))
		else $error("literal minus acc wrong");
	AST_RET_LIT: assert property (exec && instr_i[13:10] == 4'hd |=>
		acc_o == $past(lit) ##1 $stable(prog_addr_o))
		else $error("return with literal wrong");
	AST_JUMP: assert property (exec && instr_i[13:12] == 2'h2 |=>
		prog_addr_o[10:0] == $past(tgt) ##1 $stable(prog_addr_o))
		else $error("jump target or dead cycle wrong");
	AST_SLEEP: assert property (exec && instr_i == WORD_SLEEP |=>
		sleeping_o && prog_addr_o == $past(prog_addr_o) + 13'h0001)
		else $error("standby entry wrong");
	AST_SLEEP_HOLD: assert property (sleeping_o ##1 sleeping_o |->
		$stable(prog_addr_o))
		else $error("address moved in standby");
	AST_PORT_RMW: assert property ($stable(portb_pin_i)[*6] ##0
		(exec && instr_i == 14'h0886) |=> portb_out_o == $past(portb_pin_i))
		else $error("port self write did not use pins");
	AST_NOP_UNLISTED: assert property (exec && instr_i[13:8] == 6'h3b |=>
		$stable(acc_o) && prog_addr_o == $past(prog_addr_o) + 13'h0001)
		else $error("unlisted word not a no-op");

	COV_WAKE: cover property ($fell(sleeping_o));
	COV_RET: cover property (exec && instr_i[13:10] == 4'hd);
	COV_JUMP: cover property (exec && instr_i[13:12] == 2'h2);
endmodule : bcid_core_assertions

bind bcid_core bcid_core_assertions u_assert (
	.clk_i(clk_i),
	.resetn_i(resetn_i),
	.prog_addr_o(prog_addr_o),
	.instr_i(instr_i),
	.portb_pin_i(portb_pin_i),
	.portb_out_o(portb_out_o),
	.sleeping_o(sleeping_o),
	.acc_o(acc_o)
);
`default_nettype wire

// ==== bench/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic        clk_i;
	logic        resetn_i;
	logic [12:0] prog_addr_o;
	logic [13:0] instr_i;
	logic [7:0]  portb_pin_i;
	logic [7:0]  portb_out_o;
	logic        sleeping_o;
	logic [7:0]  acc_o;
	logic [7:0]  portb_oe_o;
	logic        edge_polarity_select_i;
	logic        prescaler_to_timer_i;
	logic [13:0] rom [0:127];
	int          bad_count;
	int          compares;
	int          tries;

	bcid_core u_dut (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.prog_addr_o(prog_addr_o),
		.instr_i(instr_i),
		.portb_pin_i(portb_pin_i),
		.portb_dir_i(8'hff),
		.portb_out_o(portb_out_o),
		.portb_oe_o(portb_oe_o),
		.edge_polarity_select_i(edge_polarity_select_i),
		.prescaler_to_timer_i(prescaler_to_timer_i),
		.prescale_rate_i(3'h0),
		.sleeping_o(sleeping_o),
		.acc_o(acc_o)
	);

	// Program memory answers in the same cycle, as the fetch expects
	assign instr_i = rom[prog_addr_o[6:0]];

	initial clk_i = 1'b0;
	always #2.5 clk_i = ~clk_i;

	task automatic check(input logic [12:0] seen, input logic [12:0] exp);
		compares++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic step(input int n, input logic [7:0] ea, input logic [12:0] ep);
		repeat (n) @(posedge clk_i);
		#1;
		check({5'h00, acc_o}, {5'h00, ea});
		check(prog_addr_o, ep);
	endtask : step

	task automatic complete_run();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run

	initial
	begin
		resetn_i = 1'b0;
		portb_pin_i = 8'h0a;
		edge_polarity_select_i = 1'b1;
		prescaler_to_timer_i = 1'b0;
		bad_count = 0;
		compares = 0;
		rom = '{7'h00: 14'h305a, 7'h01: 14'h00a0, 7'h02: 14'h300f,
			7'h03: 14'h0620, 7'h04: 14'h04a0, 7'h05: 14'h0820, 7'h06: 14'h3880,
			7'h07: 14'h3aff, 7'h08: 14'h3c25, 7'h09: 14'h3d30, 7'h0a: 14'h3b77,
			7'h0b: 14'h30ff, 7'h0c: 14'h0086, 7'h0d: 14'h0886, 7'h0e: 14'h3001,
			7'h0f: 14'h00a1, 7'h10: 14'h0ba1, 7'h11: 14'h30ee, 7'h12: 14'h30ff,
			7'h13: 14'h00a1, 7'h14: 14'h0f21, 7'h15: 14'h30ee, 7'h16: 14'h1821,
			7'h17: 14'h3083, 7'h18: 14'h1fa1, 7'h19: 14'h30ee, 7'h1a: 14'h00a2,
			7'h1b: 14'h01a3, 7'h1c: 14'h0ca3, 7'h1d: 14'h0d22, 7'h1e: 14'h0c22,
			7'h1f: 14'h2028, 7'h20: 14'h2830, 7'h28: 14'h343c, 7'h30: 14'h3010,
			7'h31: 14'h008b, 7'h32: 14'h30fe, 7'h33: 14'h0081, 7'h37: 14'h0063,
			7'h38: 14'h080b, 7'h39: 14'h018b, 7'h44: 14'h080b, 7'h4f: 14'h080b,
			7'h50: 14'h3060, 7'h51: 14'h0082, 7'h60: 14'h018b, 7'h69: 14'h080b,
			7'h74: 14'h080b, 7'h75: 14'h3040, 7'h76: 14'h0081, 7'h78: 14'h0801,
			7'h79: 14'h3092, 7'h7a: 14'h008b, 7'h7b: 14'h30ff,
			default: 14'h0000};
		repeat (6) @(posedge clk_i);
		resetn_i <= 1'b1;
		step(3, 8'h0f, 13'h0003);
		check({5'h00, portb_oe_o}, 13'h0000);
		step(1, 8'h55, 13'h0004);
		step(1, 8'h55, 13'h0005);
		step(1, 8'h5f, 13'h0006);
		step(1, 8'hdf, 13'h0007);
		step(1, 8'h20, 13'h0008);
		step(1, 8'h05, 13'h0009);
		step(1, 8'h2b, 13'h000a);
		step(1, 8'h2b, 13'h000b);
		step(2, 8'hff, 13'h000d);
		check({5'h00, portb_out_o}, 13'h00ff);
		step(1, 8'hff, 13'h000e);
		check({5'h00, portb_out_o}, 13'h000a);
		step(2, 8'h01, 13'h0010);
		step(2, 8'h01, 13'h0012);
		step(2, 8'hff, 13'h0014);
		step(2, 8'h00, 13'h0016);
		step(1, 8'h00, 13'h0017);
		step(3, 8'h83, 13'h001a);
		step(3, 8'h83, 13'h001d);
		step(1, 8'h06, 13'h001e);
		step(1, 8'hc1, 13'h001f);
		step(2, 8'hc1, 13'h0028);
		step(2, 8'h3c, 13'h0020);
		step(2, 8'h3c, 13'h0030);
		step(7, 8'hfe, 13'h0037);
		step(1, 8'hfe, 13'h0038);
		check({12'h000, sleeping_o}, 13'h0001);
		repeat (4) @(posedge clk_i);
		portb_pin_i <= 8'h0b;
		#1;
		check(prog_addr_o, 13'h0038);
		tries = 0;
		while (sleeping_o !== 1'b0 && tries < 20)
		begin
			@(posedge clk_i);
			#1;
			tries++;
		end
		if (tries == 20)
		begin
			bad_count++;
			complete_run();
		end
		check(prog_addr_o, 13'h0038);
		step(1, 8'h16, 13'h0039);
		step(1, 8'h16, 13'h003a);
		@(posedge clk_i) portb_pin_i <= 8'h0a;
		step(9, 8'h16, 13'h0044);
		step(1, 8'h00, 13'h0045);
		@(posedge clk_i) portb_pin_i <= 8'h1a;
		step(9, 8'h00, 13'h004f);
		step(1, 8'h01, 13'h0050);
		step(1, 8'h60, 13'h0051);
		step(2, 8'h60, 13'h0060);
		// Falling polarity: a rising pin must not set the flag, a falling one must
		@(posedge clk_i)
		begin
			edge_polarity_select_i <= 1'b0;
			portb_pin_i <= 8'h1b;
		end
		step(8, 8'h60, 13'h0069);
		step(1, 8'h00, 13'h006a);
		@(posedge clk_i) portb_pin_i <= 8'h1a;
		step(9, 8'h00, 13'h0074);
		step(1, 8'h02, 13'h0075);
		// Timer write with prescaler assigned: no tick in the next cycle
		@(posedge clk_i) prescaler_to_timer_i <= 1'b1;
		step(3, 8'h40, 13'h0079);
		// Enabled edge flag with global enable: vector, word at 0x7b not run
		step(4, 8'h92, 13'h0004);
		complete_run();
	end
endmodule : tb
`default_nettype wire

// ==== rtl/bcid_core.sv ====
`timescale 1ns/10ps
`default_nettype none
module bcid_core
	import bcid_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	// Program memory
	output logic      [12:0] prog_addr_o,
	input  wire logic [13:0] instr_i,
	// Port pins
	input  wire logic [7:0]  portb_pin_i,
	input  wire logic [7:0]  portb_dir_i,
	output logic      [7:0]  portb_out_o,
	output logic      [7:0]  portb_oe_o,
	// Configuration
	input  wire logic        edge_polarity_select_i,
	input  wire logic        prescaler_to_timer_i,
	input  wire logic [2:0]  prescale_rate_i,
	// Status
	output logic             sleeping_o,
	output logic      [7:0]  acc_o
);
	bcid_irq_if irq ();

	bcid_state_t state_reg, state_next;
	logic [12:0] pc_reg, pc_next;
	logic [7:0]  acc_reg, acc_next;
	logic [7:0]  status_reg, status_next;
	logic [4:0]  latch_reg, latch_next;
	logic [7:0]  port_reg, port_next;
	logic [7:0]  oe_reg;
	logic [7:0]  gpr [128];

	logic        wr_en;
	logic [7:0]  wr_data;
	logic        push, pop;
	logic [12:0] push_data, stack_top;
	logic        irq_ack, gie_set;

	logic [7:0]  timer_reg, timer_next;
	logic [7:0]  ps_reg, ps_next;
	logic [8:0]  ps_limit;
	logic        tick, timer_ovf;

	logic [13:0] ir;
	logic [6:0]  fa;
	logic        dst;
	logic [7:0]  kv, fv, res;
	logic [9:0]  sum;

	function automatic logic [7:0] bit_mask(input logic [2:0] b);
		bit_mask = 8'h01 << b;
	endfunction : bit_mask

	// Returns {digit carry, carry, sum}
	function automatic logic [9:0] add8(input logic [7:0] a,
		input logic [7:0] b, input logic cin);
		logic [8:0] s;
		logic [4:0] n;
		s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
		n = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		add8 = {n[4], s};
	endfunction : add8


	bcid_irq u_irq (
		.clk_i                  (clk_i),
		.resetn_i               (resetn_i),
		.portb_pin_i            (portb_pin_i),
		.portb_dir_i            (portb_dir_i),
		.edge_polarity_select_i (edge_polarity_select_i),
		.irq                    (irq.unit)
	);

	bcid_stack u_stack (
		.clk_i       (clk_i),
		.resetn_i    (resetn_i),
		.push_i      (push),
		.pop_i       (pop),
		.push_data_i (push_data),
		.top_o       (stack_top)
	);

	assign ir  = instr_i;
	assign fa  = ir[6:0];
	assign dst = ir[7];
	assign kv  = ir[7:0];

	// Operand read in a process, so a flag that moves while the same word
	// waits in standby is seen when that word finally runs
	always_comb
	begin
		case (fa)
			FA_INDIRECT:    fv = 8'h00;
			FA_TIMER:       fv = timer_reg;
			FA_PC_LOW:      fv = pc_reg[7:0];
			FA_STATUS:      fv = status_reg;
			FA_PORT:        fv = irq.pins;
			FA_UPPER_LATCH: fv = {3'h0, latch_reg};
			FA_IRQ_CTRL:    fv = irq.ctrl;
			default:        fv = gpr[fa];
		endcase
	end

	// Execution
	always_comb
	begin
		state_next  = ST_RUN;
		pc_next     = pc_reg + 13'h0001;
		acc_next    = acc_reg;
		status_next = status_reg;
		wr_en       = 1'b0;
		wr_data     = 8'h00;
		res         = fv;
		sum         = 10'h000;
		push        = 1'b0;
		pop         = 1'b0;
		push_data   = pc_reg + 13'h0001;
		irq_ack     = 1'b0;
		gie_set     = 1'b0;
		case (state_reg)
			ST_SLEEP:
			begin
				pc_next    = pc_reg;
				state_next = irq.wake ? ST_RUN : ST_SLEEP;
			end
			ST_FLUSH:
			begin
				// Second cycle of a two-cycle word does nothing
				pc_next = pc_reg;
			end
			ST_RUN:
			begin
				if (irq.req)
				begin
					// Only the address goes on the stack
					push       = 1'b1;
					push_data  = pc_reg;
					irq_ack    = 1'b1;
					pc_next    = IRQ_VEC;
					state_next = ST_FLUSH;
				end
				else
				begin
					case (ir[13:12])
						2'b00:
						begin
							case (ir[11:8])
								OP_MISC:
								begin
									if (dst)
									begin
										wr_en   = 1'b1;
										wr_data = acc_reg;
									end
									else if (ir == WORD_RETURN ||
										ir == WORD_RETURN_IRQ)
									begin
										pop        = 1'b1;
										gie_set    = ir[0];
										pc_next    = stack_top;
										state_next = ST_FLUSH;
									end
									else if (ir == WORD_SLEEP)
										state_next = ST_SLEEP;
									// Other words here fall through
								end
								OP_CLEAR:
								begin
									res = 8'h00;
									status_next[ST_Z] = 1'b1;
								end
								OP_SUB_FILE:
								begin
									sum = add8(fv, ~acc_reg, 1'b1);
									res = sum[7:0];
								end
								OP_DEC:
									res = fv - 8'h01;
								OP_OR_ACC_WITH_FILE:
									res = acc_reg | fv;
								OP_AND_FILE:
									res = acc_reg & fv;
								OP_XOR_ACC_WITH_FILE:
									res = acc_reg ^ fv;
								OP_ADD_FILE:
								begin
									sum = add8(fv, acc_reg, 1'b0);
									res = sum[7:0];
								end
								OP_MOVE:
									res = fv;
								OP_COMPLEMENT:
									res = ~fv;
								OP_INC:
									res = fv + 8'h01;
								OP_DECREMENT_SKIP_ZERO:
									res = fv - 8'h01;
								OP_ROTATE_RIGHT:
								begin
									res = {status_reg[ST_C], fv[7:1]};
									status_next[ST_C] = fv[0];
								end
								OP_ROTATE_LEFT:
								begin
									res = {fv[6:0], status_reg[ST_C]};
									status_next[ST_C] = fv[7];
								end
								OP_SWAP:
									res = {fv[3:0], fv[7:4]};
								OP_INCREMENT_SKIP_ZERO:
									res = fv + 8'h01;
								default:
									res = fv;
							endcase
							if (ir[11:8] != OP_MISC && ir[11:8] != OP_CLEAR)
							begin
								case (ir[11:8])
									OP_SUB_FILE, OP_ADD_FILE:
									begin
										status_next[ST_C]  = sum[8];
										status_next[ST_DC] = sum[9];
										status_next[ST_Z]  = (res == 8'h00);
									end
									OP_DEC, OP_OR_ACC_WITH_FILE, OP_AND_FILE,
									OP_XOR_ACC_WITH_FILE, OP_MOVE, OP_COMPLEMENT,
									OP_INC:
										status_next[ST_Z] = (res == 8'h00);
									OP_DECREMENT_SKIP_ZERO, OP_INCREMENT_SKIP_ZERO:
										if (res == 8'h00)
										begin
											pc_next    = pc_reg + 13'h0002;
											state_next = ST_FLUSH;
										end
									default:
										status_next = status_next;
								endcase
							end
							if (ir[11:8] != OP_MISC)
							begin
								if (dst)
								begin
									wr_en   = 1'b1;
									wr_data = res;
								end
								else
									acc_next = res;
							end
						end
						2'b01:
						begin
							case (ir[11:10])
								2'b00:
								begin
									wr_en   = 1'b1;
									wr_data = fv & ~bit_mask(ir[9:7]);
								end
								2'b01:
								begin
									wr_en   = 1'b1;
									wr_data = fv | bit_mask(ir[9:7]);
								end
								2'b10:
									if ((fv & bit_mask(ir[9:7])) == 8'h00)
									begin
										pc_next    = pc_reg + 13'h0002;
										state_next = ST_FLUSH;
									end
								default:
									if ((fv & bit_mask(ir[9:7])) != 8'h00)
									begin
										pc_next    = pc_reg + 13'h0002;
										state_next = ST_FLUSH;
									end
							endcase
						end
						2'b10:
						begin
							push       = ~ir[11];
							pc_next    = {latch_reg[4:3], ir[10:0]};
							state_next = ST_FLUSH;
						end
						default:
						begin
							if (ir[11:10] == 2'b00)
								acc_next = kv;
							else if (ir[11:10] == 2'b01)
							begin
								acc_next   = kv;
								pop        = 1'b1;
								pc_next    = stack_top;
								state_next = ST_FLUSH;
							end
							else if (ir[11:9] == 3'b110 || ir[11:9] == 3'b111)
							begin
								sum = ir[9] ? add8(kv, acc_reg, 1'b0) :
									add8(kv, ~acc_reg, 1'b1);
								acc_next           = sum[7:0];
								status_next[ST_C]  = sum[8];
								status_next[ST_DC] = sum[9];
								status_next[ST_Z]  = (sum[7:0] == 8'h00);
							end
							else if (ir[11:8] == LIT_OR)
							begin
								acc_next          = acc_reg | kv;
								status_next[ST_Z] = ((acc_reg | kv) == 8'h00);
							end
							else if (ir[11:8] == LIT_AND)
							begin
								acc_next          = acc_reg & kv;
								status_next[ST_Z] = ((acc_reg & kv) == 8'h00);
							end
							else if (ir[11:8] == LIT_XOR)
							begin
								acc_next          = acc_reg ^ kv;
								status_next[ST_Z] = ((acc_reg ^ kv) == 8'h00);
							end
							// Nibble 1011 is unassigned and does nothing
						end
					endcase
					if (wr_en && fa == FA_PC_LOW)
					begin
						pc_next    = {latch_reg, wr_data};
						state_next = ST_FLUSH;
					end
					if (wr_en && fa == FA_STATUS)
						status_next = wr_data;
				end
			end
			default:
				state_next = ST_RUN;
		endcase
	end

	// Side effects of file writes
	always_comb
	begin
		latch_next = latch_reg;
		port_next  = port_reg;
		if (wr_en && fa == FA_UPPER_LATCH)
			latch_next = wr_data[4:0];
		if (wr_en && fa == FA_PORT)
			port_next = wr_data;
	end

	assign irq.ctrl_wr    = wr_en && (fa == FA_IRQ_CTRL);
	assign irq.ctrl_wdata = wr_data;
	assign irq.ack        = irq_ack;
	assign irq.gie_set    = gie_set;
	assign irq.timer_ovf  = timer_ovf;

	// Timer and prescaler; the timer is frozen while asleep, an assigned prescaler keeps counting
	always_comb
	begin
		ps_limit   = (9'h002 << prescale_rate_i) - 9'h001;
		tick       = (state_reg != ST_SLEEP) &&
			(!prescaler_to_timer_i || ps_reg == ps_limit[7:0]);
		ps_next    = (tick || !prescaler_to_timer_i) ? 8'h00 :
			ps_reg + 8'h01;
		timer_next = tick ? timer_reg + 8'h01 : timer_reg;
		timer_ovf  = tick && (timer_reg == 8'hff);
		if (wr_en && fa == FA_TIMER)
		begin
			timer_next = wr_data;
			timer_ovf  = 1'b0;
			if (prescaler_to_timer_i)
				ps_next = 8'h00;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			state_reg  <= ST_RUN;
			pc_reg     <= RESET_VEC;
			acc_reg    <= ACC_RST;
			status_reg <= STATUS_RST;
			latch_reg  <= LATCH_RST;
			port_reg   <= PORT_RST;
			oe_reg     <= PORT_RST;
			timer_reg  <= TIMER_RST;
			ps_reg     <= TIMER_RST;
		end
		else
		begin
			state_reg  <= state_next;
			pc_reg     <= pc_next;
			acc_reg    <= acc_next;
			status_reg <= status_next;
			latch_reg  <= latch_next;
			port_reg   <= port_next;
			oe_reg     <= ~portb_dir_i;
			timer_reg  <= timer_next;
			ps_reg     <= ps_next;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (wr_en)
			gpr[fa] <= wr_data;
	end

	assign prog_addr_o = pc_reg;
	assign portb_out_o = port_reg;
	assign portb_oe_o  = oe_reg;
	assign sleeping_o  = state_reg[2];
	assign acc_o       = acc_reg;

endmodule : bcid_core
`default_nettype wire

// ==== rtl/bcid_irq.sv ====
`timescale 1ns/10ps
`default_nettype none
module bcid_irq
	import bcid_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       resetn_i,
	// Pins and configuration
	input  wire logic [7:0] portb_pin_i,
	input  wire logic [7:0] portb_dir_i,
	input  wire logic       edge_polarity_select_i,
	// Core side
	bcid_irq_if.unit        irq
);
	logic [7:0] s1_reg, s2_reg, s3_reg, stable_reg, prev_reg;
	logic [7:0] stable_next;
	logic [7:0] ctrl_reg, ctrl_next;
	logic       edge_hit, port_hit;

	// Two-of-three agreement filters pin glitches
	always_comb
	begin
		stable_next = (s2_reg & s3_reg) | (stable_reg & (s2_reg ^ s3_reg));
		edge_hit = edge_polarity_select_i ?
			(stable_reg[0] & ~prev_reg[0]) :
			(~stable_reg[0] & prev_reg[0]);
		port_hit = |((stable_reg[7:4] ^ prev_reg[7:4]) &
			portb_dir_i[7:4]);
		ctrl_next = irq.ctrl_wr ? irq.ctrl_wdata : ctrl_reg;
		if (irq.ack)
			ctrl_next[IRQ_GLOBAL_EN] = 1'b0;
		if (irq.gie_set)
			ctrl_next[IRQ_GLOBAL_EN] = 1'b1;
		// Sets are applied last so an event beats a same-cycle clear
		if (edge_hit)
			ctrl_next[IRQ_EDGE_FLAG] = 1'b1;
		if (irq.timer_ovf)
			ctrl_next[IRQ_TIMER_FLAG] = 1'b1;
		if (port_hit)
			ctrl_next[IRQ_PORT_FLAG] = 1'b1;
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			s1_reg     <= PORT_RST;
			s2_reg     <= PORT_RST;
			s3_reg     <= PORT_RST;
			stable_reg <= PORT_RST;
			prev_reg   <= PORT_RST;
			ctrl_reg   <= IRQ_CTRL_RST;
		end
		else
		begin
			s1_reg     <= portb_pin_i;
			s2_reg     <= s1_reg;
			s3_reg     <= s2_reg;
			stable_reg <= stable_next;
			prev_reg   <= stable_reg;
			ctrl_reg   <= ctrl_next;
		end
	end

	assign irq.pins = stable_reg;
	assign irq.ctrl = ctrl_reg;
	// Enables 5:3 pair with flags 2:0; wake ignores the global enable
	assign irq.wake = |(ctrl_reg[IRQ_TIMER_EN -: 3] &
		ctrl_reg[IRQ_TIMER_FLAG -: 3]);
	assign irq.req = ctrl_reg[IRQ_GLOBAL_EN] & irq.wake;

endmodule : bcid_irq
`default_nettype wire

// ==== rtl/bcid_irq_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface bcid_irq_if;
	logic [7:0] pins;
	logic       ctrl_wr;
	logic [7:0] ctrl_wdata;
	logic [7:0] ctrl;
	logic       timer_ovf;
	logic       ack;
	logic       gie_set;
	logic       wake;
	logic       req;

	modport unit (
		input  ctrl_wr, ctrl_wdata, timer_ovf, ack, gie_set,
		output pins, ctrl, wake, req
	);
	modport core (
		output ctrl_wr, ctrl_wdata, timer_ovf, ack, gie_set,
		input  pins, ctrl, wake, req
	);
endinterface : bcid_irq_if
`default_nettype wire

// ==== rtl/bcid_pkg.sv ====
package bcid_pkg;

	// File register map
	localparam logic [6:0]  FA_INDIRECT     = 7'h00;
	localparam logic [6:0]  FA_TIMER        = 7'h01;
	localparam logic [6:0]  FA_PC_LOW       = 7'h02;
	localparam logic [6:0]  FA_STATUS       = 7'h03;
	localparam logic [6:0]  FA_PORT         = 7'h06;
	localparam logic [6:0]  FA_UPPER_LATCH  = 7'h0a;
	localparam logic [6:0]  FA_IRQ_CTRL     = 7'h0b;

	// Status bits
	localparam int unsigned ST_C            = 0;
	localparam int unsigned ST_DC           = 1;
	localparam int unsigned ST_Z            = 2;

	// Interrupt control register bits
	localparam int unsigned IRQ_GLOBAL_EN   = 7;
	localparam int unsigned IRQ_TIMER_EN    = 5;
	localparam int unsigned IRQ_EDGE_EN     = 4;
	localparam int unsigned IRQ_PORT_EN     = 3;
	localparam int unsigned IRQ_TIMER_FLAG  = 2;
	localparam int unsigned IRQ_EDGE_FLAG   = 1;
	localparam int unsigned IRQ_PORT_FLAG   = 0;

	// Reset values and vectors
	localparam logic [12:0] RESET_VEC       = 13'h0000;
	localparam logic [12:0] IRQ_VEC         = 13'h0004;
	localparam logic [7:0]  STATUS_RST      = 8'h18;
	localparam logic [7:0]  IRQ_CTRL_RST    = 8'h00;
	localparam logic [4:0]  LATCH_RST       = 5'h00;
	localparam logic [7:0]  TIMER_RST       = 8'h00;
	localparam logic [7:0]  PORT_RST        = 8'h00;
	localparam logic [7:0]  ACC_RST         = 8'h00;
	localparam logic [2:0]  STACK_PTR_RST   = 3'h0;

	// Byte-operation nibbles
	localparam logic [3:0]  OP_MISC         = 4'h0;
	localparam logic [3:0]  OP_CLEAR        = 4'h1;
	localparam logic [3:0]  OP_SUB_FILE     = 4'h2;
	localparam logic [3:0]  OP_DEC          = 4'h3;
	localparam logic [3:0]  OP_OR_ACC_WITH_FILE  = 4'h4;
	localparam logic [3:0]  OP_AND_FILE     = 4'h5;
	localparam logic [3:0]  OP_XOR_ACC_WITH_FILE = 4'h6;
	localparam logic [3:0]  OP_ADD_FILE     = 4'h7;
	localparam logic [3:0]  OP_MOVE         = 4'h8;
	localparam logic [3:0]  OP_COMPLEMENT   = 4'h9;
	localparam logic [3:0]  OP_INC          = 4'ha;
	localparam logic [3:0]  OP_DECREMENT_SKIP_ZERO = 4'hb;
	localparam logic [3:0]  OP_ROTATE_RIGHT = 4'hc;
	localparam logic [3:0]  OP_ROTATE_LEFT  = 4'hd;
	localparam logic [3:0]  OP_SWAP         = 4'he;
	localparam logic [3:0]  OP_INCREMENT_SKIP_ZERO = 4'hf;

	// Literal nibbles
	localparam logic [3:0]  LIT_OR          = 4'h8;
	localparam logic [3:0]  LIT_AND         = 4'h9;
	localparam logic [3:0]  LIT_XOR         = 4'ha;

	// Fixed control words
	localparam logic [13:0] WORD_RETURN     = 14'h0008;
	localparam logic [13:0] WORD_RETURN_IRQ = 14'h0009;
	localparam logic [13:0] WORD_SLEEP      = 14'h0063;

	typedef enum logic [2:0] {
		ST_RUN   = 3'b001,
		ST_FLUSH = 3'b010,
		ST_SLEEP = 3'b100
	} bcid_state_t;

endpackage : bcid_pkg

// ==== rtl/bcid_stack.sv ====
`timescale 1ns/10ps
`default_nettype none
module bcid_stack
	import bcid_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	// Push and pop
	input  wire logic        push_i,
	input  wire logic        pop_i,
	input  wire logic [12:0] push_data_i,
	output logic      [12:0] top_o
);
	logic [12:0] mem [8];
	logic [2:0]  ptr_reg;
	logic [2:0]  ptr_next;

	// Pointer wraps, so a ninth push lands on the first entry
	always_comb
	begin
		ptr_next = ptr_reg;
		if (push_i)
			ptr_next = ptr_reg + 3'h1;
		else if (pop_i)
			ptr_next = ptr_reg - 3'h1;
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			ptr_reg <= STACK_PTR_RST;
		else
			ptr_reg <= ptr_next;
	end

	always_ff @(posedge clk_i)
	begin
		if (push_i)
			mem[ptr_reg] <= push_data_i;
	end

	assign top_o = mem[ptr_reg - 3'h1];

endmodule : bcid_stack
`default_nettype wire
